// *** rtl/srl_defines.vh ***
`ifndef SRL_DEFINES_VH
`define SRL_DEFINES_VH

// =====================================================
// Register map (word aligned byte addresses)
`define SRL_ADDR_CTRL 12'h000
`define SRL_ADDR_STAT 12'h004
`define SRL_ADDR_CFG 12'h008
`define SRL_ADDR_W 12

// =====================================================
// Control register fields
`define SRL_CTRL_TX 0
`define SRL_CTRL_LIBMODE 1
// Status register fields
`define SRL_STAT_RX 0
`define SRL_STAT_DONE 1
`define SRL_STAT_TRAP 2
`define SRL_STAT_LOADING 3
`define SRL_STAT_EMPTY 4

// =====================================================
// Shift clock periods in core cycles
`define SRL_PERIOD_NORM 256
`define SRL_PERIOD_FAST 16
`define SRL_DIV_W 8
`define SRL_HALF_NORM 8'h80
`define SRL_HALF_FAST 8'h08

// =====================================================
// Load sequencer states
`define SRL_ST_IDLE 2'h0
`define SRL_ST_LOAD 2'h1
`define SRL_ST_DONE 2'h2
`define SRL_ST_W 2

`define SRL_ZERO32 32'h0000_0000

`endif

// *** rtl/srl_sync3.v ***
`timescale 1ns/100ps
`include "srl_defines.vh"

// =====================================================
// Three flop synchroniser; a change counts when the last two agree
module srl_sync3 (
   input wire clk,
   input wire rst_n,
   input wire din,
   output reg dout
);
   reg s1_r;
   reg s2_r;
   reg s3_r;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
         dout <= 1'b0;
      end else begin
         s1_r <= din;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r) begin
            dout <= s3_r;
         end
      end
   end
endmodule // srl_sync3

// *** rtl/srl_loader.v ***
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/100ps
`include "srl_defines.vh"

// Behaviour
// - Enable low for whole cache fill
// - Enable high and held after load
// - One enable is ROM output enable and reset
// - Each rising shift clock edge captures data bit
// - Normal shift clock period 256 cycles
// - Fast flag gives 16 cycle period
// - Every cache data and tag bit loaded serially
// - After load pins become software UART
// - After load clock pin follows transmit bit
// - Transmit bit resets to zero, software writable
// - Transmit appears only after write retires
// - Receive bit mirrors input, transitions trap
// - Library mode blocks all interrupts
// - Shift clock has 50 percent duty
// - Cache filled low to high addresses
// - Zero fetch count loads no lines
module srl_loader #(
   parameter ADDR_W = 10,
   parameter LINE_W = 32,
   parameter COUNT_W = 10
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire fast_load_flag,
   input wire rom_serial_in,
   output reg rom_enable_n,
   output reg rom_shift_clock,
   input wire privileged_reg_write,
   input wire privileged_library_mode,
   output reg core_reset_n,
   output reg trap_req,
   output reg cache_we,
   output reg [ADDR_W-1:0] cache_addr,
   output reg [LINE_W-1:0] cache_wdata
);

   // =====================================================
   // Registers
   reg [`SRL_ST_W-1:0] state_r;
   reg [`SRL_ST_W-1:0] state_nxt;
   reg [`SRL_DIV_W-1:0] div_r;
   reg [COUNT_W-1:0] count_r;
   reg count_done_r;
   reg [COUNT_W-1:0] cnt_bits_r;
   reg [LINE_W-1:0] shift_r;
   reg [7:0] bit_idx_r;
   reg [COUNT_W-1:0] lines_left_r;
   reg tx_pend_r;
   reg serial_tx_bit_r;
   reg lib_mode_r;
   reg rx_prev_r;
   reg trap_sticky_r;
   reg empty_r;
   wire serial_rx_bit;
   wire [`SRL_DIV_W-1:0] half;
   wire shift_edge;
   wire wr_en;
   wire rd_en;

   assign pready = 1'b1;
   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & ~penable & ~pwrite;

   // =====================================================
   // Input synchroniser
   // synchronised receive input
   srl_sync3 u_sync (
      .clk(pclk),
      .rst_n(presetn),
      .din(rom_serial_in),
      .dout(serial_rx_bit)
   );

   // =====================================================
   // Shift clock divider
   // normal or fast half period
   assign half = fast_load_flag ? `SRL_HALF_FAST : `SRL_HALF_NORM;
   assign shift_edge = (state_r == `SRL_ST_LOAD) && (div_r == half - 8'h01);

   function is_mapped;
      input [`SRL_ADDR_W-1:0] a;
      begin
         is_mapped = (a == `SRL_ADDR_CTRL) || (a == `SRL_ADDR_STAT) ||
            (a == `SRL_ADDR_CFG);
      end
   endfunction

   assign pslverr = psel & penable & ~is_mapped(paddr);

   // =====================================================
   // Capture helpers
   wire rise_edge;
   wire fall_edge;
   wire count_last;
   wire trap_clear;
   wire [COUNT_W-1:0] count_in;
   wire [LINE_W-1:0] line_in;

   function [COUNT_W-1:0] push_count;
      input [COUNT_W-1:0] cur;
      input b;
      begin
         push_count = {b, cur[COUNT_W-1:1]};
      end
   endfunction

   function [LINE_W-1:0] push_line;
      input [LINE_W-1:0] cur;
      input b;
      begin
         push_line = {b, cur[LINE_W-1:1]};
      end
   endfunction

   // Capture on the rising half so the synchronised bit had a full half period to settle
   assign rise_edge = shift_edge && !rom_shift_clock;
   assign fall_edge = shift_edge && rom_shift_clock;
   assign count_last = rise_edge && !count_done_r && (cnt_bits_r == COUNT_W - 1);
   assign trap_clear = wr_en && (paddr == `SRL_ADDR_STAT) && pwdata[`SRL_STAT_TRAP];
   // Load data shares the receive synchroniser; the pin is asynchronous to pclk
   assign count_in = push_count(count_r, serial_rx_bit);
   assign line_in = push_line(shift_r, serial_rx_bit);

   // =====================================================
   // Sequencer
   always @* begin
      state_nxt = state_r;
      case (state_r)
         `SRL_ST_IDLE: begin
            state_nxt = `SRL_ST_LOAD;
         end
         `SRL_ST_LOAD: begin
            if (count_done_r && (cnt_bits_r == {COUNT_W{1'b0}})) begin
               state_nxt = `SRL_ST_DONE;
            end else if (count_done_r && fall_edge &&
                  (lines_left_r == {COUNT_W{1'b0}})) begin
               // Finish on the falling edge after the last capture
               state_nxt = `SRL_ST_DONE;
            end
         end
         `SRL_ST_DONE: begin
            state_nxt = `SRL_ST_DONE;
         end
         default: begin
            state_nxt = `SRL_ST_IDLE;
         end
      endcase
   end

   // =====================================================
   // State and pin enables
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= `SRL_ST_IDLE;
         rom_enable_n <= 1'b1;
         core_reset_n <= 1'b0;
      end else begin
         state_r <= state_nxt;
         rom_enable_n <= (state_nxt != `SRL_ST_LOAD);
         core_reset_n <= (state_nxt == `SRL_ST_DONE);
      end
   end

   // =====================================================
   // Shift clock pin
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_r <= 8'h00;
         rom_shift_clock <= 1'b0;
      end else begin
         if (state_nxt == `SRL_ST_DONE) begin
            // clock pin follows transmit bit
            // Handed over in the same cycle, so core release never sees a high clock
            div_r <= 8'h00;
            rom_shift_clock <= serial_tx_bit_r;
         end else if (state_r == `SRL_ST_LOAD) begin
            if (div_r == half - 8'h01) begin
               div_r <= 8'h00;
               rom_shift_clock <= ~rom_shift_clock;
            end else begin
               div_r <= div_r + 8'h01;
            end
         end
      end
   end

   // =====================================================
   // Fetch count capture
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_r <= {COUNT_W{1'b0}};
         count_done_r <= 1'b0;
         cnt_bits_r <= {COUNT_W{1'b0}};
         empty_r <= 1'b0;
      end else begin
         if (rise_edge && !count_done_r) begin
            count_r <= count_in;
            cnt_bits_r <= cnt_bits_r + {{(COUNT_W-1){1'b0}}, 1'b1};
            if (count_last) begin
               // Bit counter is reused to hold the count once it is complete
               count_done_r <= 1'b1;
               cnt_bits_r <= count_in;
               empty_r <= (count_in == {COUNT_W{1'b0}});
            end
         end
      end
   end

   // =====================================================
   // Line assembly
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shift_r <= {LINE_W{1'b0}};
         bit_idx_r <= 8'h00;
         lines_left_r <= {COUNT_W{1'b0}};
         cache_we <= 1'b0;
         cache_wdata <= {LINE_W{1'b0}};
      end else begin
         cache_we <= 1'b0;
         if (count_last) begin
            lines_left_r <= count_in;
         end
         if (rise_edge && count_done_r) begin
            // every bit from the serial stream
            shift_r <= line_in;
            if (bit_idx_r == LINE_W - 1) begin
               bit_idx_r <= 8'h00;
               cache_we <= 1'b1;
               cache_wdata <= line_in;
               lines_left_r <= lines_left_r - {{(COUNT_W-1){1'b0}}, 1'b1};
            end else begin
               bit_idx_r <= bit_idx_r + 8'h01;
            end
         end
      end
   end

   // =====================================================
   // Fill address
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cache_addr <= {ADDR_W{1'b0}};
      end else begin
         if (cache_we) begin
            cache_addr <= cache_addr + {{(ADDR_W-1){1'b0}}, 1'b1};
         end
      end
   end

   // =====================================================
   // Transmit control
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         serial_tx_bit_r <= 1'b0;
         tx_pend_r <= 1'b0;
         lib_mode_r <= 1'b0;
      end else begin
         if (wr_en && paddr == `SRL_ADDR_CTRL) begin
            tx_pend_r <= pwdata[`SRL_CTRL_TX];
            lib_mode_r <= pwdata[`SRL_CTRL_LIBMODE];
         end
         if (privileged_reg_write) begin
            serial_tx_bit_r <= tx_pend_r;
         end
      end
   end

   // =====================================================
   // Receive transition trap
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_prev_r <= 1'b0;
         trap_req <= 1'b0;
         trap_sticky_r <= 1'b0;
      end else begin
         trap_req <= 1'b0;
         rx_prev_r <= serial_rx_bit;
         // blocked in library mode
         // A new transition wins over a clear in the same cycle
         if ((state_r == `SRL_ST_DONE) && (serial_rx_bit != rx_prev_r) &&
               !privileged_library_mode && !lib_mode_r) begin
            trap_req <= 1'b1;
            trap_sticky_r <= 1'b1;
         end else if (trap_clear) begin
            trap_sticky_r <= 1'b0;
         end
      end
   end

   // =====================================================
   // Read data, loaded in the setup cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= `SRL_ZERO32;
      end else begin
         if (rd_en) begin
            prdata <= `SRL_ZERO32;
            case (paddr)
               `SRL_ADDR_CTRL: begin
                  prdata[`SRL_CTRL_TX] <= serial_tx_bit_r;
                  prdata[`SRL_CTRL_LIBMODE] <= lib_mode_r;
               end
               `SRL_ADDR_STAT: begin
                  prdata[`SRL_STAT_RX] <= serial_rx_bit;
                  prdata[`SRL_STAT_DONE] <= (state_r == `SRL_ST_DONE);
                  prdata[`SRL_STAT_TRAP] <= trap_sticky_r;
                  prdata[`SRL_STAT_LOADING] <= (state_r == `SRL_ST_LOAD);
                  prdata[`SRL_STAT_EMPTY] <= empty_r;
               end
               `SRL_ADDR_CFG: begin
                  prdata[COUNT_W-1:0] <= count_r;
               end
               default: begin
                  prdata <= `SRL_ZERO32;
               end
            endcase
         end
      end
   end
endmodule // srl_loader

// *** tb/srl_loader_sva.sv ***
`timescale 1ns/100ps
// ==========
// Pin checker
module srl_loader_sva #(
   parameter ADDR_W = 10
) (
   input wire pclk,
   input wire presetn,
   input wire fast_load_flag,
   input wire rom_serial_in,
   input wire rom_enable_n,
   input wire rom_shift_clock,
   input wire privileged_reg_write,
   input wire privileged_library_mode,
   input wire core_reset_n,
   input wire trap_req,
   input wire cache_we,
   input wire [ADDR_W-1:0] cache_addr
);
   logic [7:0] run_r;
   logic prev_r;
   logic [ADDR_W-1:0] wr_r;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Level run length; eight bits hold the 128 cycle phase
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_r <= 8'h00;
         prev_r <= 1'b0;
         wr_r <= '0;
      end else begin
         prev_r <= rom_shift_clock;
         run_r <= (rom_shift_clock == prev_r) ? run_r + 8'h01 : 8'h01;
         wr_r <= wr_r + {{(ADDR_W-1){1'b0}}, cache_we};
      end
   end
   sequence s_rx_edge;
      $changed(rom_serial_in) && core_reset_n && !privileged_library_mode;
   endsequence
   a_core_held: assert property (
      !rom_enable_n |-> !core_reset_n) else $error("core out of reset");
   a_load_end: assert property (
      core_reset_n |=> core_reset_n && rom_enable_n) else $error("load resumed");
   a_half_period: assert property (
      $fell(rom_shift_clock) && !rom_enable_n |->
      run_r == (fast_load_flag ? 8'h08 : 8'h80)) else $error("bad high phase");
   a_fill_order: assert property (
      cache_we |-> !core_reset_n && cache_addr == wr_r) else $error("bad fill");
   a_tx_reset: assert property (
      $rose(core_reset_n) |-> !rom_shift_clock) else $error("tx not low");
   a_tx_retire: assert property (
      core_reset_n && $past(core_reset_n) && $changed(rom_shift_clock) |->
      $past(privileged_reg_write, 2)) else $error("tx moved early");
   a_trap_follow: assert property (
      s_rx_edge |-> ##[1:6] (trap_req || privileged_library_mode)) else $error("no trap");
   a_trap_pulse: assert property (
      trap_req |-> core_reset_n && !$past(privileged_library_mode) ##1 !trap_req)
      else $error("bad trap");
endmodule // srl_loader_sva
bind srl_loader srl_loader_sva #(.ADDR_W(ADDR_W)) u_sva (
   .pclk(pclk), .presetn(presetn), .fast_load_flag(fast_load_flag),
   .rom_serial_in(rom_serial_in), .rom_enable_n(rom_enable_n),
   .rom_shift_clock(rom_shift_clock), .privileged_reg_write(privileged_reg_write),
   .privileged_library_mode(privileged_library_mode), .core_reset_n(core_reset_n),
   .trap_req(trap_req), .cache_we(cache_we), .cache_addr(cache_addr));

// *** tb/srl_rom_model.sv ***
`timescale 1ns/100ps
// ==========
// Serial ROM, then terminal line
module srl_rom_model (
   input wire pclk,
   input wire rom_enable_n,
   input wire rom_shift_clock,
   input wire term_line,
   input wire [31:0] image,
   output wire rom_serial_in
);
   logic [4:0] idx_r;
   logic [1:0] seen_r;
   // Enable high resets; a rise advances after the hold time
   always @(posedge pclk) begin
      seen_r <= {seen_r[0], rom_shift_clock};
      if (rom_enable_n)
         idx_r <= 5'h00;
      else if (seen_r == 2'b01)
         idx_r <= idx_r + 5'h01;
   end
   // Receiver drives the line once the ROM lets go
   assign rom_serial_in = rom_enable_n ? term_line : image[idx_r];
endmodule // srl_rom_model

// *** tb/tb.sv ***
`timescale 1ns/100ps
`include "srl_defines.vh"
// ==========
// Loader bench
module tb;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic fast = 1'b1, prw = 1'b0, plib = 1'b0, term = 1'b1, pe;
   logic pready, pslverr, oe_n, sclk, core_rst_n, trap, we, rom_in;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, img = 32'h0000_0000, prdata, rd;
   logic [3:0] wa;
   logic [7:0] wdt;
   int errors, checks, nw, cyc;
   srl_loader #(.ADDR_W(4), .LINE_W(8), .COUNT_W(4)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .fast_load_flag(fast), .rom_serial_in(rom_in), .rom_enable_n(oe_n),
      .rom_shift_clock(sclk), .privileged_reg_write(prw), .privileged_library_mode(plib),
      .core_reset_n(core_rst_n), .trap_req(trap), .cache_we(we), .cache_addr(wa),
      .cache_wdata(wdt));
   srl_rom_model rom (.pclk(pclk), .rom_enable_n(oe_n), .rom_shift_clock(sclk),
      .term_line(term), .image(img), .rom_serial_in(rom_in));
   initial begin
      forever #12.5 pclk = ~pclk;
   end
   task chk(input string n, input logic [7:0] g, input logic [7:0] e);
      checks++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s exp %h got %h", n, e, g);
      end
   endtask
   task complete_run;
      if (errors == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 6000) begin
         errors++;
         complete_run;
      end
      if (we === 1'b1) begin
         chk("addr", 8'(wa), 8'(nw));
         chk("data", wdt, img[4+8*nw +: 8]);
         nw++;
      end
   end
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      pe = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task boot(input logic f, input logic [31:0] m, input logic t);
      @(posedge pclk);
      presetn <= 1'b0;
      fast <= f;
      img <= m;
      term <= t;
      nw = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      do @(posedge pclk); while (core_rst_n !== 1'b1);
      chk("done", 8'({oe_n, sclk}), 8'h02);
      chk("lines", 8'(nw), 8'(m[3:0]));
   endtask
   task t_tx;
      apb(1'b1, `SRL_ADDR_CTRL, 32'h0000_0001);
      @(posedge pclk);
      prw <= 1'b1;
      @(posedge pclk);
      prw <= 1'b0;
      @(negedge pclk);
      chk("tx early", 8'(sclk), 8'h00);
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      chk("tx pin", 8'(sclk), 8'h01);
   endtask
   task t_rx;
      int k;
      for (int m = 0; m < 2; m++) begin
         @(posedge pclk);
         plib <= m[0];
         term <= ~term;
         k = 0;
         repeat (8) @(posedge pclk) k += (trap === 1'b1);
         chk("traps", 8'(k), 8'(1 - m));
         apb(1'b0, `SRL_ADDR_STAT, 32'h0000_0000);
         chk("rx", 8'(rd[`SRL_STAT_RX]), 8'(term));
      end
   endtask
   initial begin
      boot(1'b1, 32'h000B_CA52, 1'b1);
      t_tx;
      t_rx;
      apb(1'b0, 12'h00C, 32'h0000_0000);
      chk("slverr", 8'(pe), 8'h01);
      boot(1'b0, 32'h0000_0000, 1'b0);
      complete_run;
   end
endmodule // tb
